// ==== hdl/fcu_pkg.sv ====
// constants and types shared by the fast counter unit
// =====================================================================
// Notes on behaviour
// RULE1 - two arrangements: four pulse counters, or quadrature plus one pulse counter
// RULE2 - in quadrature arrangement channels one to three merge; channel four stays pulse
// RULE3 - quadrature counter ignores direction, mode and count edge settings
// RULE4 - normal failure mode: outputs keep following counters after run to stop
// RULE5 - forced-off failure mode: outputs inactive in stop, counters keep counting
// RULE6 - hold failure mode: outputs frozen in stop, counters keep counting
// RULE7 - stop response lasts until run returns, then counters drive outputs
// RULE8 - per-channel enable, default off; disabled channel counts nothing, uses no pins
// RULE9 - pulse channel direction up or down, default up
// RULE10 - pulse channel continuous or one-shot mode, default continuous
// RULE11 - channel one output enable works only with width and train outputs off
// RULE12 - width and train outputs unavailable in quadrature arrangement
// RULE13 - upper limit defaults to 32767, the largest count held
// RULE14 - rate window defaults to 1000 ms
// RULE15 - load value enters accumulator on load input and on stop to run
// RULE16 - quadrature counter counts every transition of its two inputs
// RULE17 - aux input acts as load or strobe, edge selectable; default load, rising
// RULE18 - count edge selectable, default rising; accumulator kept within limits
package fcu_pkg;
   // =================================================================
   // sizes
   localparam int DW = 16;
   localparam int AW = 8;
   localparam int NCH = 4;
   // =================================================================
   // register offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h01;
   localparam logic [3:0] OFS_CFG = 4'h0;
   localparam logic [3:0] OFS_WIN = 4'h1;
   localparam logic [3:0] OFS_UPPER = 4'h2;
   localparam logic [3:0] OFS_LOWER = 4'h3;
   localparam logic [3:0] OFS_ON = 4'h4;
   localparam logic [3:0] OFS_OFF = 4'h5;
   localparam logic [3:0] OFS_LOAD = 4'h6;
   localparam logic [3:0] OFS_ACC = 4'h8;
   localparam logic [3:0] OFS_STROBE = 4'h9;
   localparam logic [3:0] OFS_RATE = 4'ha;
   // =================================================================
   // field positions
   localparam int CTRL_QUAD = 0;
   localparam int CTRL_FAIL = 1;
   localparam int CFG_EN = 0;
   localparam int CFG_OE = 1;
   localparam int CFG_DOWN = 2;
   localparam int CFG_ONESHOT = 3;
   localparam int CFG_STROBE = 4;
   localparam int CFG_AUXNEG = 5;
   localparam int CFG_CNTNEG = 6;
   localparam int CFG_PWM = 7;
   localparam int CFG_PULSE = 8;
   // =================================================================
   // reset values
   localparam logic [15:0] CFG_RST = 16'h0000;
   localparam logic [15:0] UPPER_RST = 16'h7fff;
   localparam logic [15:0] LOWER_RST = 16'h0000;
   localparam logic [15:0] ON_RST = 16'h7fff;
   localparam logic [15:0] OFF_RST = 16'h0000;
   localparam logic [15:0] LOAD_RST = 16'h0000;
   localparam logic [15:0] WIN_MS_RST = 16'h03e8;
   // =================================================================
   // timing
   localparam int CLK_PERIOD_NS = 20;
   localparam int MS_NS = 1000000;
   localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
   // =================================================================
   // modes and states
   typedef enum logic [1:0] {
      FAIL_NORMAL = 2'h0,
      FAIL_FORCED = 2'h1,
      FAIL_HOLD = 2'h2
   } fcu_fail_t;
   typedef enum logic {
      RUN_STOPPED = 1'h0,
      RUN_ACTIVE = 1'h1
   } fcu_run_t;
endpackage : fcu_pkg

// ==== hdl/fcu_channel.sv ====
// one accumulator channel of the fast counter unit
`timescale 1ns/1ps
module fcu_channel #(
   parameter int W = fcu_pkg::DW
) (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // control
   input wire logic en,
   input wire logic step,
   input wire logic up,
   input wire logic one_shot,
   input wire logic load_now,
   input wire logic strobe_now,
   input wire logic ms_tick,
   // settings
   input wire logic [W-1:0] load_value,
   input wire logic [W-1:0] upper,
   input wire logic [W-1:0] lower,
   input wire logic [W-1:0] on_th,
   input wire logic [W-1:0] off_th,
   input wire logic [W-1:0] rate_window,
   // results
   output logic [W-1:0] acc,
   output logic [W-1:0] strobe_val,
   output logic [W-1:0] rate,
   output logic preset_out
);
   typedef struct packed {
      logic [W-1:0] acc;
      logic [W-1:0] strobe_val;
      logic [W-1:0] events;
      logic [W-1:0] rate;
      logic [W-1:0] ms;
      logic done;
      logic pout;
   } fcu_ch_state_t;

   fcu_ch_state_t r;
   fcu_ch_state_t next_r;

   function automatic logic fcu_gt(input logic [W-1:0] a, input logic [W-1:0] b);
      return $signed(a) > $signed(b);
   endfunction : fcu_gt

   // =================================================================
   // next state
   always_comb begin
      next_r = r;
      if (en) begin
         if (load_now) begin
            next_r.acc = load_value; // RULE15
            next_r.done = 1'b0;
         end else if (step && !r.done) begin
            if (up) begin // RULE9
               if (!fcu_gt(upper, r.acc)) begin
                  if (one_shot) begin // RULE10
                     next_r.done = 1'b1;
                  end else begin
                     next_r.acc = lower; // RULE18
                  end
               end else begin
                  next_r.acc = r.acc + W'(1);
               end
            end else begin
               if (!fcu_gt(r.acc, lower)) begin
                  if (one_shot) begin // RULE10
                     next_r.done = 1'b1;
                  end else begin
                     next_r.acc = upper; // RULE18
                  end
               end else begin
                  next_r.acc = r.acc - W'(1);
               end
            end
         end
         if (strobe_now) begin
            next_r.strobe_val = r.acc; // RULE17
         end
         if (step) begin
            next_r.events = r.events + W'(1);
         end
         if (ms_tick) begin
            // window 0 behaves as 1 ms rather than never closing
            if ({1'b0, r.ms} + (W+1)'(1) >= {1'b0, rate_window}) begin
               next_r.rate = next_r.events;
               next_r.events = '0;
               next_r.ms = '0;
            end else begin
               next_r.ms = r.ms + W'(1);
            end
         end
         // on below off gives a band, otherwise the band wraps
         if (!fcu_gt(on_th, off_th)) begin
            next_r.pout = fcu_gt(r.acc, on_th) && !fcu_gt(r.acc, off_th);
         end else begin
            next_r.pout = fcu_gt(r.acc, on_th) || !fcu_gt(r.acc, off_th);
         end
      end else begin
         next_r.pout = 1'b0; // RULE8
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign acc = r.acc;
   assign strobe_val = r.strobe_val;
   assign rate = r.rate;
   assign preset_out = r.pout;

   // =================================================================
   // checks
   a_idle_when_off: // RULE8
   assert property (@(posedge clk) disable iff (!resetn) !en |=> $stable(acc) && !preset_out)
      else $error("disabled channel changed state");
   a_load_taken: // RULE15
   assert property (@(posedge clk) disable iff (!resetn) en && load_now |=> acc == $past(load_value))
      else $error("load value not taken");
   a_one_shot_stop: // RULE10
   assert property (@(posedge clk) disable iff (!resetn) en && r.done && !load_now |=> $stable(acc))
      else $error("one-shot channel kept counting");
   a_wrap_upper: // RULE18
   assert property (@(posedge clk) disable iff (!resetn)
      en && step && up && !one_shot && !load_now && !r.done && acc == upper |=> acc == $past(lower))
      else $error("no wrap at upper limit");
   a_count_down: // RULE9
   assert property (@(posedge clk) disable iff (!resetn)
      en && step && !up && !load_now && !r.done && fcu_gt(acc, lower) |=> acc == $past(acc) - W'(1))
      else $error("down count wrong");
endmodule : fcu_channel

// ==== hdl/fcu_counter_unit.sv ====
// fast counter unit: configuration, edge and quadrature decode, failure-mode outputs
`timescale 1ns/1ps
module fcu_counter_unit #(
   parameter int MS_CYCLES = fcu_pkg::MS_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // register port
   input wire logic [fcu_pkg::AW-1:0] reg_addr,
   input wire logic [fcu_pkg::DW-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [fcu_pkg::DW-1:0] reg_rdata,
   // controller mode, high while in run
   input wire logic controller_run,
   // field inputs
   input wire logic [fcu_pkg::NCH-1:0] count_in,
   input wire logic [fcu_pkg::NCH-1:0] aux_in,
   // discrete outputs
   output logic [fcu_pkg::NCH-1:0] counter_out
);
   localparam int N = fcu_pkg::NCH;
   localparam int D = fcu_pkg::DW;

   default clocking @(posedge clk);
   endclocking
   default disable iff (!resetn);

   typedef struct packed {
      logic quad;
      fcu_pkg::fcu_fail_t fail;
      fcu_pkg::fcu_run_t run;
      logic [N-1:0][D-1:0] cfg;
      logic [N-1:0][D-1:0] win;
      logic [N-1:0][D-1:0] upper;
      logic [N-1:0][D-1:0] lower;
      logic [N-1:0][D-1:0] on_th;
      logic [N-1:0][D-1:0] off_th;
      logic [N-1:0][D-1:0] load;
      logic [N-1:0] cnt_prev;
      logic [N-1:0] aux_prev;
      logic [N-1:0] out;
      logic [D-1:0] rdata;
      logic [15:0] ms;
   } fcu_state_t;

   fcu_state_t r;
   fcu_state_t next_r;

   // 0 means no channel, otherwise channel index plus one
   function automatic logic [2:0] fcu_chan_sel(input logic [fcu_pkg::AW-1:0] a);
      logic [2:0] sel;
      sel = 3'h0;
      if (a[7:4] >= 4'h1 && a[7:4] <= 4'(N)) begin
         sel = a[6:4];
      end
      return sel;
   endfunction : fcu_chan_sel

   // =================================================================
   // channel steering
   logic [N-1:0] ch_en;
   logic [N-1:0] step;
   logic [N-1:0] up;
   logic [N-1:0] one_shot;
   logic [N-1:0] load_now;
   logic [N-1:0] strobe_now;
   logic [N-1:0] oen;
   logic [N-1:0] live;
   logic [N-1:0] pout_w;
   logic [N-1:0][D-1:0] acc_w;
   logic [N-1:0][D-1:0] strobe_w;
   logic [N-1:0][D-1:0] rate_w;
   logic quad_step;
   logic quad_up;
   logic pwm_eff;
   logic pulse_eff;
   logic start_pulse;
   logic ms_tick;

   always_comb begin
      start_pulse = (r.run == fcu_pkg::RUN_STOPPED) && controller_run;
      ms_tick = (r.ms == 16'(MS_CYCLES - 1));
      // every change of either quadrature input is one count
      quad_step = (count_in[1:0] != r.cnt_prev[1:0]); // RULE16
      quad_up = r.cnt_prev[0] ^ count_in[1];
      pwm_eff = r.cfg[0][fcu_pkg::CFG_PWM] && !r.quad; // RULE12
      pulse_eff = r.cfg[0][fcu_pkg::CFG_PULSE] && !r.quad; // RULE12
      for (int i = 0; i < N; i++) begin
         ch_en[i] = r.cfg[i][fcu_pkg::CFG_EN];
         if (r.quad && (i == 1 || i == 2)) begin
            ch_en[i] = 1'b0; // RULE2
         end
         if (r.cfg[i][fcu_pkg::CFG_CNTNEG]) begin // RULE18
            step[i] = ch_en[i] && !count_in[i] && r.cnt_prev[i];
         end else begin
            step[i] = ch_en[i] && count_in[i] && !r.cnt_prev[i];
         end
         up[i] = !r.cfg[i][fcu_pkg::CFG_DOWN];
         one_shot[i] = r.cfg[i][fcu_pkg::CFG_ONESHOT];
         if (r.cfg[i][fcu_pkg::CFG_AUXNEG]) begin // RULE17
            strobe_now[i] = ch_en[i] && !aux_in[i] && r.aux_prev[i];
         end else begin
            strobe_now[i] = ch_en[i] && aux_in[i] && !r.aux_prev[i];
         end
         load_now[i] = (strobe_now[i] && !r.cfg[i][fcu_pkg::CFG_STROBE]) || start_pulse; // RULE15
         strobe_now[i] = strobe_now[i] && r.cfg[i][fcu_pkg::CFG_STROBE];
         oen[i] = r.cfg[i][fcu_pkg::CFG_OE];
      end
      if (r.quad) begin // RULE1
         // direction, mode and edge settings play no part here
         step[0] = ch_en[0] && quad_step; // RULE3
         up[0] = quad_up; // RULE3
         one_shot[0] = 1'b0; // RULE3
      end
      oen[0] = oen[0] && !pwm_eff && !pulse_eff; // RULE11
      for (int i = 0; i < N; i++) begin
         live[i] = ch_en[i] && oen[i] && pout_w[i]; // RULE8
      end
   end

   // =================================================================
   // channels
   for (genvar g = 0; g < N; g++) begin : g_ch
      fcu_channel #(
         .W(D)
      ) u_ch (
         .clk(clk),
         .resetn(resetn),
         .en(ch_en[g]),
         .step(step[g]),
         .up(up[g]),
         .one_shot(one_shot[g]),
         .load_now(load_now[g]),
         .strobe_now(strobe_now[g]),
         .ms_tick(ms_tick),
         .load_value(r.load[g]),
         .upper(r.upper[g]),
         .lower(r.lower[g]),
         .on_th(r.on_th[g]),
         .off_th(r.off_th[g]),
         .rate_window(r.win[g]),
         .acc(acc_w[g]),
         .strobe_val(strobe_w[g]),
         .rate(rate_w[g]),
         .preset_out(pout_w[g])
      );
   end

   // =================================================================
   // registers, outputs and read port
   always_comb begin
      logic [2:0] sel;
      logic [1:0] ci;
      sel = fcu_chan_sel(reg_addr);
      ci = 2'(sel - 3'h1);
      next_r = r;
      next_r.cnt_prev = count_in;
      next_r.aux_prev = aux_in;
      next_r.run = controller_run ? fcu_pkg::RUN_ACTIVE : fcu_pkg::RUN_STOPPED;
      next_r.ms = ms_tick ? 16'h0000 : r.ms + 16'h0001;
      // stop response stays until run is back
      if (r.run == fcu_pkg::RUN_ACTIVE) begin
         next_r.out = live; // RULE7
      end else begin
         unique case (r.fail)
            fcu_pkg::FAIL_FORCED: next_r.out = '0; // RULE5
            fcu_pkg::FAIL_HOLD: next_r.out = r.out; // RULE6
            default: next_r.out = live; // RULE4
         endcase
      end
      if (reg_wr) begin
         if (reg_addr == fcu_pkg::OFS_CTRL) begin
            next_r.quad = reg_wdata[fcu_pkg::CTRL_QUAD]; // RULE1
            next_r.fail = fcu_pkg::fcu_fail_t'(reg_wdata[fcu_pkg::CTRL_FAIL +: 2]);
         end else if (sel != 3'h0) begin
            unique case (reg_addr[3:0])
               fcu_pkg::OFS_CFG: next_r.cfg[ci] = {7'h00, reg_wdata[8:0]};
               fcu_pkg::OFS_WIN: next_r.win[ci] = reg_wdata;
               fcu_pkg::OFS_UPPER: next_r.upper[ci] = reg_wdata;
               fcu_pkg::OFS_LOWER: next_r.lower[ci] = reg_wdata;
               fcu_pkg::OFS_ON: next_r.on_th[ci] = reg_wdata;
               fcu_pkg::OFS_OFF: next_r.off_th[ci] = reg_wdata;
               fcu_pkg::OFS_LOAD: next_r.load[ci] = reg_wdata;
               default: ;
            endcase
         end
      end
      next_r.rdata = '0;
      if (reg_rd) begin
         if (reg_addr == fcu_pkg::OFS_CTRL) begin
            next_r.rdata = {13'h0000, r.fail, r.quad};
         end else if (reg_addr == fcu_pkg::OFS_STATUS) begin
            next_r.rdata = {5'h00, pulse_eff, pwm_eff, r.run, ch_en, r.out};
         end else if (sel != 3'h0) begin
            unique case (reg_addr[3:0])
               fcu_pkg::OFS_CFG: next_r.rdata = r.cfg[ci];
               fcu_pkg::OFS_WIN: next_r.rdata = r.win[ci];
               fcu_pkg::OFS_UPPER: next_r.rdata = r.upper[ci];
               fcu_pkg::OFS_LOWER: next_r.rdata = r.lower[ci];
               fcu_pkg::OFS_ON: next_r.rdata = r.on_th[ci];
               fcu_pkg::OFS_OFF: next_r.rdata = r.off_th[ci];
               fcu_pkg::OFS_LOAD: next_r.rdata = r.load[ci];
               fcu_pkg::OFS_ACC: next_r.rdata = acc_w[ci];
               fcu_pkg::OFS_STROBE: next_r.rdata = strobe_w[ci];
               fcu_pkg::OFS_RATE: next_r.rdata = rate_w[ci];
               default: next_r.rdata = '0;
            endcase
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         r <= '0;
         r.fail <= fcu_pkg::FAIL_NORMAL; // RULE4
         r.run <= fcu_pkg::RUN_STOPPED;
         r.cfg <= {N{fcu_pkg::CFG_RST}}; // RULE8
         r.win <= {N{fcu_pkg::WIN_MS_RST}}; // RULE14
         r.upper <= {N{fcu_pkg::UPPER_RST}}; // RULE13
         r.lower <= {N{fcu_pkg::LOWER_RST}};
         r.on_th <= {N{fcu_pkg::ON_RST}};
         r.off_th <= {N{fcu_pkg::OFF_RST}};
         r.load <= {N{fcu_pkg::LOAD_RST}};
      end else begin
         r <= next_r;
      end
   end

   assign reg_rdata = r.rdata;
   assign counter_out = r.out;

   // =================================================================
   // checks
   sequence s_stopped_in(fcu_pkg::fcu_fail_t m);
      r.run == fcu_pkg::RUN_STOPPED && r.fail == m;
   endsequence
   sequence s_start;
      r.run == fcu_pkg::RUN_STOPPED ##0 controller_run;
   endsequence
   sequence s_stop_entry;
      r.run == fcu_pkg::RUN_ACTIVE ##0 !controller_run;
   endsequence

   a_forced_off: // RULE5
   assert property (@(posedge clk) disable iff (!resetn)
      s_stopped_in(fcu_pkg::FAIL_FORCED) |=> counter_out == 4'h0)
      else $error("outputs not forced off in stop");

   a_hold_frozen: // RULE6
   assert property (@(posedge clk) disable iff (!resetn)
      s_stopped_in(fcu_pkg::FAIL_HOLD) |=> counter_out == $past(counter_out))
      else $error("outputs moved while held");

   a_normal_follows: // RULE4
   assert property (@(posedge clk) disable iff (!resetn)
      s_stopped_in(fcu_pkg::FAIL_NORMAL) |=> counter_out == $past(live))
      else $error("normal stop outputs not from counters");

   a_run_returns: // RULE7
   assert property (@(posedge clk) disable iff (!resetn)
      s_start |=> ##1 counter_out == $past(live))
      else $error("outputs not back under counter control");

   a_start_loads: // RULE15
   assert property (@(posedge clk) disable iff (!resetn)
      s_start ##0 ch_en[0] |=> acc_w[0] == $past(r.load[0]))
      else $error("no load at stop to run");

   a_quad_merged: // RULE2
   assert property (@(posedge clk) disable iff (!resetn) r.quad |-> !ch_en[1] && !ch_en[2] && !live[1])
      else $error("merged channels still active");

   a_quad_edges: // RULE16
   assert property (@(posedge clk) disable iff (!resetn)
      r.quad && ch_en[0] && count_in[1:0] != $past(count_in[1:0]) |-> step[0] && !one_shot[0])
      else $error("quadrature transition not counted");

   a_no_width_quad: // RULE12
   assert property (@(posedge clk) disable iff (!resetn) r.quad |-> !pwm_eff && !pulse_eff)
      else $error("width or train output in quadrature arrangement");

   a_out1_gate: // RULE11
   assert property (@(posedge clk) disable iff (!resetn) pwm_eff || pulse_eff |-> !oen[0] && !live[0])
      else $error("channel one output enabled beside width or train output");

   a_rdata_idle:
   assert property (!reg_rd |=> reg_rdata == 16'h0000)
      else $error("read data not zero outside a read");

   a_unmapped_read:
   assert property (reg_rd && reg_addr > fcu_pkg::OFS_STATUS && fcu_chan_sel(reg_addr) == 3'h0
      |=> reg_rdata == 16'h0000)
      else $error("unmapped address read non-zero");

   a_ctrl_taken: // RULE1
   assert property (reg_wr && reg_addr == fcu_pkg::OFS_CTRL
      |=> r.quad == $past(reg_wdata[fcu_pkg::CTRL_QUAD]))
      else $error("arrangement not taken from write");

   a_run_copied: // RULE7
   assert property (controller_run |=> r.run == fcu_pkg::RUN_ACTIVE)
      else $error("run state not following controller");

   a_live_in_run: // RULE7
   assert property (r.run == fcu_pkg::RUN_ACTIVE |=> counter_out == $past(live))
      else $error("outputs not under counter control in run");

   a_stop_entry: // RULE4
   assert property (s_stop_entry |=> counter_out == $past(live))
      else $error("stop entry changed the outputs");

   a_start_pulse: // RULE15
   assert property (s_start |-> load_now == '1)
      else $error("stop to run did not load every channel");

   a_stop_counts: // RULE5
   assert property (r.run == fcu_pkg::RUN_STOPPED && r.cfg[0][fcu_pkg::CFG_EN] |-> ch_en[0])
      else $error("stop halted a counter");

   a_quad_settings: // RULE3
   assert property (r.quad |-> up[0] == quad_up && !one_shot[0])
      else $error("quadrature counter used direction or mode setting");

   a_width_four: // RULE12
   assert property (!r.quad && r.cfg[0][fcu_pkg::CFG_PWM] |-> pwm_eff)
      else $error("width output lost in four-counter arrangement");

   a_tick_bound:
   assert property (r.ms < 16'(MS_CYCLES))
      else $error("millisecond divider out of range");

   for (genvar k = 0; k < N; k++) begin : g_chk
      a_off_quiet: // RULE8
      assert property (r.run == fcu_pkg::RUN_ACTIVE && !ch_en[k] |=> !counter_out[k])
         else $error("disabled channel drove its output");
      a_strobe_taken: // RULE17
      assert property (strobe_now[k] |=> strobe_w[k] == $past(acc_w[k]))
         else $error("strobe capture wrong");
      a_load_value: // RULE15
      assert property (load_now[k] && ch_en[k] |=> acc_w[k] == $past(r.load[k]))
         else $error("load value not in accumulator");
      a_cfg_top_zero:
      assert property (r.cfg[k][15:9] == 7'h00)
         else $error("unused configuration bits set");
   end
endmodule : fcu_counter_unit

// ==== tb/fcu_field_model.sv ====
// field-side model: count, quadrature and aux lines of the counter unit
`timescale 1ns/1ps
module fcu_field_model (
   // clock
   input wire logic clk,
   // one-cycle requests and the quadrature select level from the bench
   input wire logic [3:0] tog_cnt,
   input wire logic [3:0] tog_aux,
   input wire logic quad,
   input wire logic q_up,
   input wire logic q_dn,
   // field lines
   output logic [3:0] count_in,
   output logic [3:0] aux_in
);
   // =====================================================
   // line state
   logic [3:0] cnt = 4'h0;
   logic [3:0] aux = 4'h0;
   logic [1:0] ph = 2'h0;
   always_ff @(posedge clk) begin
      cnt <= cnt ^ tog_cnt;
      aux <= aux ^ tog_aux;
      ph <= ph + {q_dn, q_up | q_dn};
   end
   // gray phase: only one of a and b moves per step
   assign count_in = quad ? {cnt[3:2], ph[1] ^ ph[0], ph[1]} : cnt;
   assign aux_in = aux;
endmodule : fcu_field_model

// ==== tb/fcu_counter_unit_bench.sv ====
// self-checking bench for the fast counter unit
`timescale 1ns/1ps
module fcu_counter_unit_bench;
   // =====================================================
   // signals
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [15:0] reg_rdata;
   logic controller_run = 1'b0;
   logic [3:0] count_in;
   logic [3:0] aux_in;
   logic [3:0] counter_out;
   logic [3:0] tc = 4'h0;
   logic [3:0] ta = 4'h0;
   logic quad = 1'b0;
   logic q_up = 1'b0;
   logic q_dn = 1'b0;
   logic [15:0] s;
   int fails = 0;
   int checks = 0;
   logic [15:0] dflt [7] = '{16'h0000, 16'h03e8, 16'h7fff, 16'h0000, 16'h7fff, 16'h0000, 16'h0000};
   // =====================================================
   // instances
   fcu_counter_unit #(.MS_CYCLES(10)) i_dut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .controller_run(controller_run), .count_in(count_in), .aux_in(aux_in), .counter_out(counter_out));
   fcu_field_model i_field (.clk(clk), .tog_cnt(tc), .tog_aux(ta), .quad(quad), .q_up(q_up),
      .q_dn(q_dn), .count_in(count_in), .aux_in(aux_in));
   initial begin
      forever #10 clk = ~clk;
   end
   // =====================================================
   // tasks
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask : wt
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic ck(input logic [7:0] a, input logic [15:0] exp);
      logic [15:0] d;
      rd(a, d);
      chk(d, exp);
   endtask : ck
   task automatic co(input logic exp);
      wt(2);
      #1 chk({15'h0000, counter_out[0]}, {15'h0000, exp});
   endtask : co
   // toggles with a gap cycle so every change is seen alone
   task automatic tg(input logic [3:0] c, input logic [3:0] a, input int n);
      repeat (n) begin
         @(posedge clk);
         tc <= c;
         ta <= a;
         @(posedge clk);
         tc <= 4'h0;
         ta <= 4'h0;
      end
      wt(4);
   endtask : tg
   task automatic qs(input logic u, input int n);
      repeat (n) begin
         @(posedge clk);
         q_up <= u;
         q_dn <= !u;
         @(posedge clk);
         q_up <= 1'b0;
         q_dn <= 1'b0;
      end
      wt(4);
   endtask : qs
   task automatic go(input logic r);
      @(posedge clk);
      controller_run <= r;
      wt(5);
   endtask : go
   task automatic wrap_up;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : wrap_up
   // =====================================================
   // tests
   initial begin
      wt(5);
      resetn <= 1'b1;
      for (int i = 0; i < 7; i++) begin
         ck({4'h1, i[3:0]}, dflt[i]);
         ck({4'h4, i[3:0]}, dflt[i]);
      end
      wr(8'h18, 16'h1234);
      wr(8'h77, 16'h1234);
      ck(8'h18, 16'h0000);
      ck(8'h77, 16'h0000);
      ck(8'h00, 16'h0000);
      tg(4'h1, 4'h0, 4);
      ck(8'h18, 16'h0000);
      ck(8'h01, 16'h0000);
      $display("test defaults done");
      wr(8'h10, 16'h0001);
      wr(8'h12, 16'h0005);
      wr(8'h16, 16'h0003);
      go(1'b1);
      ck(8'h18, 16'h0003);
      tg(4'h1, 4'h0, 4);
      ck(8'h18, 16'h0005);
      tg(4'h1, 4'h0, 2);
      ck(8'h18, 16'h0000);
      wr(8'h10, 16'h0005);
      tg(4'h1, 4'h0, 2);
      ck(8'h18, 16'h0005);
      tg(4'h1, 4'h0, 2);
      ck(8'h18, 16'h0004);
      wr(8'h10, 16'h0045);
      tg(4'h1, 4'h0, 1);
      ck(8'h18, 16'h0004);
      tg(4'h1, 4'h0, 1);
      ck(8'h18, 16'h0003);
      wr(8'h10, 16'h000d);
      tg(4'h1, 4'h0, 8);
      ck(8'h18, 16'h0000);
      tg(4'h0, 4'h1, 1);
      ck(8'h18, 16'h0003);
      tg(4'h1, 4'h0, 2);
      ck(8'h18, 16'h0002);
      wr(8'h10, 16'h0011);
      tg(4'h0, 4'h1, 2);
      ck(8'h19, 16'h0002);
      ck(8'h18, 16'h0002);
      $display("test counting done");
      wr(8'h10, 16'h0003);
      wr(8'h15, 16'h0003);
      wr(8'h14, 16'h0000);
      co(1'b1);
      go(1'b0);
      tg(4'h1, 4'h0, 4);
      co(1'b0);
      ck(8'h18, 16'h0004);
      go(1'b1);
      co(1'b1);
      wr(8'h00, 16'h0002);
      go(1'b0);
      co(1'b0);
      tg(4'h1, 4'h0, 2);
      ck(8'h18, 16'h0004);
      go(1'b1);
      co(1'b1);
      wr(8'h00, 16'h0004);
      go(1'b0);
      tg(4'h1, 4'h0, 4);
      co(1'b1);
      ck(8'h18, 16'h0005);
      go(1'b1);
      wr(8'h10, 16'h0083);
      co(1'b0);
      rd(8'h01, s);
      chk(s & 16'h0200, 16'h0200);
      $display("test failure modes done");
      wr(8'h00, 16'h0001);
      wr(8'h10, 16'h00cd);
      wr(8'h20, 16'h0001);
      wr(8'h40, 16'h0001);
      @(posedge clk);
      quad <= 1'b1;
      tg(4'h0, 4'h1, 2);
      ck(8'h18, 16'h0003);
      qs(1'b1, 3);
      ck(8'h18, 16'h0000);
      qs(1'b0, 2);
      ck(8'h18, 16'h0004);
      ck(8'h28, 16'h0000);
      tg(4'h8, 4'h0, 4);
      ck(8'h48, 16'h0002);
      wr(8'h44, 16'h0000);
      wr(8'h45, 16'h0003);
      wr(8'h40, 16'h0003);
      wt(2);
      #1 chk({12'h000, counter_out}, 16'h0008);
      rd(8'h01, s);
      chk(s & 16'h06f0, 16'h0090);
      $display("test quadrature done");
      wrap_up();
   end
   initial begin
      #400000;
      fails++;
      wrap_up();
   end
endmodule : fcu_counter_unit_bench
